/* core/sfp_top.sv */
// serial flash page program, clear flag status and status polling
`include "sfp_cfg.svh"
module sfp_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        spi_sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  dq_in,
  output logic      [3:0]  dq_out,
  output logic      [3:0]  dq_oe,
  input  wire logic [1:0]  proto_mode,
  input  wire logic [15:0] prot_sect,
  input  wire logic        pgm_stall,
  input  wire logic [11:0] rd_addr,
  output logic      [7:0]  rd_data,
  output logic      [7:0]  status_out,
  output logic      [7:0]  flag_out
);

  // ---------------- link side, clocked by spi_sck ----------------
  logic [1:0]           proto_s;  // protocol pins, synced to sck
  sfp_pkg::sfp_stat_t   stat_q;   // core status, registered
  sfp_pkg::sfp_stat_t   stat_s;   // core status, synced to sck
  logic                 busy_s;   // programming running
  logic                 fresh_q;  // no edge seen yet in this frame
  logic                 seq_q;    // toggles once per clocked frame
  sfp_pkg::sfp_frame_t  fr_q;     // opcode, address, counts
  logic [7:0]           sh_q;     // partial byte being shifted in
  logic [7:0]           dcnt_q;   // data bytes taken, wraps
  logic [7:0]           buf_mem [`SFP_PAGE_BYTES]; // page buffer
  logic [255:0]         mask_q;   // buffer bytes written this frame
  logic [7:0]           out_sh_q; // status byte being shifted out
  logic [2:0]           obit_q;   // bits of it already sent
  logic [2:0]           bc_b;     // byte count seen by this edge
  logic [2:0]           bp_b;     // bit position seen by this edge
  logic [7:0]           sh_b;     // partial byte seen by this edge
  logic [2:0]           w_c;      // lanes used by this edge
  logic [3:0]           nb_c;     // bit position after this edge
  logic [7:0]           byte_c;   // shift register after this edge
  logic                 bdone_c;  // byte completes on this edge
  logic [7:0]           wa_c;     // buffer slot for a data byte
  logic                 dwr_c;    // data byte written on this edge
  logic                 rd_act_c; // status byte is being read out
  logic [2:0]           ow_c;     // output lanes
  logic [7:0]           cur_c;    // byte whose top bits go out now

  // lanes per clock for a given phase of a command
  function automatic logic [2:0] lane_w(
    input logic [1:0] pm,
    input logic [7:0] op,
    input logic [2:0] bc
  );
    logic [2:0] w;
    w = 3'd1;
    if (pm == sfp_pkg::PROTO_QUAD) begin
      w = 3'd4;
    end else if (pm == sfp_pkg::PROTO_DUAL) begin
      w = 3'd2;
    end else if (bc == 3'd0) begin
      w = 3'd1;
    end else if (bc < 3'd4) begin
      // extended protocol, address phase
      if (op == `SFP_OP_XDPP) begin
        w = 3'd2;
      end else if (op == `SFP_OP_XQPP) begin
        w = 3'd4;
      end
    end else begin
      // extended protocol, data phase
      if (op == `SFP_OP_DPP || op == `SFP_OP_XDPP) begin
        w = 3'd2;
      end else if (op == `SFP_OP_QPP || op == `SFP_OP_XQPP) begin
        w = 3'd4;
      end
    end
    return w;
  endfunction : lane_w

  // shift w lane bits into the bottom of a byte
  function automatic logic [7:0] shift_in(
    input logic [7:0] sh,
    input logic [3:0] dq,
    input logic [2:0] w
  );
    logic [7:0] r;
    case (w)
      3'd4:    r = {sh[3:0], dq[3:0]};
      3'd2:    r = {sh[5:0], dq[1:0]};
      default: r = {sh[6:0], dq[0]};
    endcase
    return r;
  endfunction : shift_in

  // program family opcodes
  function automatic logic is_prog(input logic [7:0] op);
    return op == `SFP_OP_PP || op == `SFP_OP_QPP ||
           op == `SFP_OP_XQPP || op == `SFP_OP_DPP ||
           op == `SFP_OP_XDPP;
  endfunction : is_prog

  // config pins and core status cross into the sck domain
  sfp_sync #(.W(2), .RV(1'b0)) u_proto_sync (
    .clk   (spi_sck),
    .rst_n (rst_n),
    .d     (proto_mode),
    .q     (proto_s)
  );
  sfp_sync #(.W(16), .RV(1'b0)) u_stat_sync (
    .clk   (spi_sck),
    .rst_n (rst_n),
    .d     (stat_q),
    .q     (stat_s)
  );
  assign busy_s = stat_s.sr[`SFP_SR_WIP];

  // per-edge decode; a fresh frame starts from zero counts
  always_comb begin
    bc_b    = fresh_q ? 3'd0 : fr_q.bcnt;
    bp_b    = fresh_q ? 3'd0 : fr_q.bitpos;
    sh_b    = fresh_q ? 8'h00 : sh_q;
    w_c     = lane_w(proto_s, fr_q.op, bc_b);
    nb_c    = {1'b0, bp_b} + {1'b0, w_c};
    byte_c  = shift_in(sh_b, dq_in, w_c);
    bdone_c = nb_c[3];
    wa_c    = fr_q.addr[7:0] + dcnt_q;
    // buffer frozen while the engine reads it
    dwr_c   = bdone_c && (bc_b >= 3'd4) && !busy_s;
  end

  // frame start marker; select high rearms it without a clock
  always_ff @(posedge spi_sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // input shifter; counts hold after the frame for the core to read
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      fr_q   <= '0;
      sh_q   <= 8'h00;
      dcnt_q <= 8'h00;
      seq_q  <= 1'b0;
    end else begin
      if (fresh_q) begin
        seq_q <= ~seq_q; // tells the core this frame was clocked
      end
      fr_q.bitpos <= nb_c[2:0];
      sh_q        <= byte_c;
      fr_q.bcnt   <= (bdone_c && bc_b != 3'd7) ? bc_b + 3'd1 : bc_b;
      if (bdone_c) begin
        if (bc_b == 3'd0) begin
          fr_q.op <= byte_c;
          dcnt_q  <= 8'h00;
        end else if (bc_b < 3'd4) begin
          fr_q.addr <= {fr_q.addr[15:0], byte_c};
        end else if (dwr_c) begin
          dcnt_q <= dcnt_q + 8'h01; // wraps inside the page
        end
      end
    end
  end

  // page buffer; later bytes overwrite earlier ones in place
  always_ff @(posedge spi_sck) begin
    if (dwr_c) begin
      buf_mem[wa_c] <= byte_c;
    end
  end

  // which buffer bytes this frame supplied; rest stay untouched
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (dwr_c) begin
      if (bc_b == 3'd4) begin
        mask_q <= 256'(1) << wa_c; // first data byte
      end else begin
        mask_q <= mask_q | (256'(1) << wa_c);
      end
    end
  end

  // status readout decode; allowed at any time, also while busy
  always_comb begin
    rd_act_c = !fresh_q && (fr_q.bcnt != 3'd0) &&
               (fr_q.op == `SFP_OP_RDSR || fr_q.op == `SFP_OP_RDFS);
    ow_c     = lane_w(proto_s, 8'h00, 3'd0);
    if (obit_q != 3'd0) begin
      cur_c = out_sh_q;
    end else if (fr_q.op == `SFP_OP_RDSR) begin
      cur_c = stat_s.sr;
    end else begin
      cur_c = stat_s.fsr;
    end
  end

  // output lanes change on the falling edge; released on select high
  always_ff @(negedge spi_sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n) begin
      dq_out   <= 4'h0;
      dq_oe    <= 4'h0;
      out_sh_q <= 8'h00;
      obit_q   <= 3'd0;
    end else if (rd_act_c) begin
      case (ow_c)
        3'd4: begin
          dq_out <= cur_c[7:4];
          dq_oe  <= 4'hf;
        end
        3'd2: begin
          dq_out <= {2'b00, cur_c[7:6]};
          dq_oe  <= 4'h3;
        end
        default: begin
          dq_out <= {2'b00, cur_c[7], 1'b0}; // single lane reads on lane 1
          dq_oe  <= 4'h2;
        end
      endcase
      out_sh_q <= shift_in(cur_c, 4'h0, ow_c);
      obit_q   <= obit_q + ow_c; // byte repeats after wrap
    end else begin
      dq_oe <= 4'h0;
    end
  end

  // ---------------- core side, clocked by core_clk ----------------
  logic                 cs_s;    // select, synced
  logic                 cs_d_q;  // select, one cycle later
  logic                 seq_s;   // frame toggle, synced
  logic                 seen_q;  // last frame toggle acted on
  logic [15:0]          prot_s;  // protected sector map, synced
  logic                 stall_s; // programming held off, synced
  sfp_pkg::sfp_state_t  st_q;    // program engine state
  logic [9:0]           cnt_q;   // program time counter
  logic [7:0]           idx_q;   // byte being applied to the array
  logic [3:0]           pg_q;    // page being programmed
  logic                 wip_q;   // write in progress
  logic                 wel_q;   // write enable latch
  logic                 perr_q;  // program error flag
  logic                 prerr_q; // protection error flag
  logic                 eerr_q;  // erase error flag
  logic                 susp_q;  // program suspended
  logic [7:0]           arr_mem [`SFP_ARR_BYTES]; // flash array
  logic                 exec_c, algn_c, opok_c, cmd_c;
  logic                 preq_c, prot_c, go_c, run_c;
  logic                 to_c, ppok_c, clr_c, wr_c;
  logic [11:0]          waddr_c; // array byte being programmed
  logic [7:0]           sr_c, fsr_c;

  sfp_sync #(.W(1), .RV(1'b1)) u_cs_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (cs_n),
    .q     (cs_s)
  );
  sfp_sync #(.W(1), .RV(1'b0)) u_seq_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (seq_q),
    .q     (seq_s)
  );
  sfp_sync #(.W(17), .RV(1'b0)) u_pin_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({pgm_stall, prot_sect}),
    .q     ({stall_s, prot_s})
  );

  // frame end decode; sck is still, so the link fields are stable
  always_comb begin
    exec_c  = cs_s && !cs_d_q && (seq_s != seen_q);
    algn_c  = (fr_q.bitpos == 3'd0);
    opok_c  = exec_c && (fr_q.bcnt != 3'd0);
    cmd_c   = opok_c && algn_c;
    preq_c  = cmd_c && is_prog(fr_q.op) && (fr_q.bcnt >= `SFP_MIN_PGM) &&
              wel_q && (st_q == sfp_pkg::ST_IDLE);
    prot_c  = preq_c && prot_s[fr_q.addr[11:8]];
    go_c    = preq_c && !prot_c;
    run_c   = !susp_q;
    to_c    = (st_q == sfp_pkg::ST_WAIT) && run_c &&
              (cnt_q == 10'(`SFP_TO_CYC - 1));
    ppok_c  = (st_q == sfp_pkg::ST_WAIT) && run_c && !stall_s && !to_c &&
              (cnt_q >= 10'(`SFP_PP_CYC - 1));
    clr_c   = opok_c && (fr_q.op == `SFP_OP_CLFS);
    waddr_c = {pg_q, idx_q};
    wr_c    = (st_q == sfp_pkg::ST_APPLY) && run_c && mask_q[idx_q];
  end

  // frame end edge and frame toggle bookkeeping
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_q <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      cs_d_q <= cs_s;
      if (cs_s && !cs_d_q) begin
        seen_q <= seq_s;
      end
    end
  end

  // program engine: wait the program time, then apply the buffer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= sfp_pkg::ST_IDLE;
      cnt_q <= 10'h000;
      idx_q <= 8'h00;
      pg_q  <= 4'h0;
      wip_q <= 1'b0;
    end else begin
      case (st_q)
        sfp_pkg::ST_IDLE: begin
          if (go_c) begin
            st_q  <= sfp_pkg::ST_WAIT;
            cnt_q <= 10'h000;
            pg_q  <= fr_q.addr[11:8];
            wip_q <= 1'b1;
          end
        end
        sfp_pkg::ST_WAIT: begin
          if (to_c) begin
            st_q <= sfp_pkg::ST_END; // failed, array left alone
          end else if (ppok_c) begin
            st_q  <= sfp_pkg::ST_APPLY;
            idx_q <= 8'h00;
          end else if (run_c) begin
            cnt_q <= cnt_q + 10'h001;
          end
        end
        sfp_pkg::ST_APPLY: begin
          if (run_c) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'hff) begin
              st_q <= sfp_pkg::ST_END;
            end
          end
        end
        sfp_pkg::ST_END: begin
          st_q  <= sfp_pkg::ST_IDLE;
          wip_q <= 1'b0;
        end
        default: begin
          st_q  <= sfp_pkg::ST_IDLE;
          wip_q <= 1'b0;
        end
      endcase
    end
  end

  // array: erased at reset, programming can only clear bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SFP_ARR_BYTES; i++) begin
        arr_mem[i] <= `SFP_ERASED;
      end
    end else if (wr_c) begin
      arr_mem[waddr_c] <= arr_mem[waddr_c] & buf_mem[idx_q];
    end
  end

  // array inspection port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= arr_mem[rd_addr];
    end
  end

  // latch and flags; a hardware set wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_q   <= 1'b0;
      perr_q  <= 1'b0;
      prerr_q <= 1'b0;
      eerr_q  <= 1'b0;
      susp_q  <= 1'b0;
    end else begin
      if (st_q == sfp_pkg::ST_END) begin
        wel_q <= 1'b0;
      end else if (to_c) begin
        wel_q <= 1'b0;
      end else if (cmd_c && fr_q.op == `SFP_OP_WREN) begin
        wel_q <= 1'b1;
      end else if (cmd_c && fr_q.op == `SFP_OP_WRDI && !prerr_q) begin
        wel_q <= 1'b0;
      end else if (clr_c && prerr_q) begin
        wel_q <= 1'b0;
      end
      perr_q  <= prot_c || to_c || (perr_q && !clr_c);
      prerr_q <= prot_c || (prerr_q && !clr_c);
      eerr_q  <= eerr_q && !clr_c;
      if (st_q == sfp_pkg::ST_END) begin
        susp_q <= 1'b0;
      end else if (cmd_c && fr_q.op == `SFP_OP_SUSP &&
                   st_q != sfp_pkg::ST_IDLE) begin
        susp_q <= 1'b1;
      end else if (cmd_c && fr_q.op == `SFP_OP_RESM) begin
        susp_q <= 1'b0;
      end
    end
  end

  // register images of status and flag status
  always_comb begin
    sr_c               = 8'h00;
    sr_c[`SFP_SR_WIP]  = wip_q;
    sr_c[`SFP_SR_WEL]  = wel_q;
    fsr_c              = 8'h00;
    fsr_c[`SFP_FS_RDY]  = (st_q == sfp_pkg::ST_IDLE) || susp_q;
    fsr_c[`SFP_FS_EERR] = eerr_q;
    fsr_c[`SFP_FS_PERR] = perr_q;
    fsr_c[`SFP_FS_PSUS] = susp_q;
    fsr_c[`SFP_FS_PROT] = prerr_q;
  end

  // status outputs and the copy sent across to the link side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q     <= '0;
      status_out <= 8'h00;
      flag_out   <= 8'h00;
    end else begin
      stat_q     <= {fsr_c, sr_c};
      status_out <= sr_c;
      flag_out   <= fsr_c;
    end
  end

  // ---------------- checks ----------------
  logic [7:0] old_c; // array byte before a program write
  assign old_c = arr_mem[waddr_c];

  a_clr_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    clr_c && !to_c |=> !perr_q && !prerr_q && !eerr_q)
    else $error("flag clear left an error bit set");

  a_start_wel: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == sfp_pkg::ST_IDLE ##1 st_q == sfp_pkg::ST_WAIT) |-> $past(wel_q))
    else $error("program started without write enable");

  a_ragged_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_c && !algn_c && st_q == sfp_pkg::ST_IDLE &&
    fr_q.op != `SFP_OP_CLFS |=> st_q == sfp_pkg::ST_IDLE &&
    wel_q == $past(wel_q) && perr_q == $past(perr_q))
    else $error("unaligned frame end had an effect");

  a_prot_hit: assert property (@(posedge core_clk) disable iff (!rst_n)
    prot_c |=> wel_q && prerr_q && perr_q && st_q == sfp_pkg::ST_IDLE)
    else $error("protected program not refused properly");

  a_time_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    to_c |=> !wel_q && perr_q ##1 !wip_q)
    else $error("timeout did not fail the program");

  a_no_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_c |=> (arr_mem[$past(waddr_c)] & ~$past(old_c)) == 8'h00)
    else $error("programming set an array bit");

  a_wip_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q != sfp_pkg::ST_IDLE) == wip_q)
    else $error("write in progress out of step with engine");

  a_end_wel: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q == sfp_pkg::ST_END |=> !wel_q && !wip_q)
    else $error("latch or busy left set after program end");

  a_susp_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    susp_q && st_q != sfp_pkg::ST_IDLE |=> $stable(idx_q) && $stable(cnt_q))
    else $error("suspended program kept running");

  a_wren_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_c && fr_q.op == `SFP_OP_WREN && st_q != sfp_pkg::ST_END &&
    !to_c |=> wel_q)
    else $error("write enable did not set the latch");

  a_wrdi_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_c && fr_q.op == `SFP_OP_WRDI && prerr_q && !to_c &&
    st_q != sfp_pkg::ST_END |=> wel_q == $past(wel_q))
    else $error("write disable cleared latch after protection error");

endmodule : sfp_top

/* core/sfp_cfg.svh */
// constants of the serial flash page program block
// Summary of operation
// - clear flag status resets all error flags
// - command bits use one, two or four lanes
// - clear flag status finishes whenever select rises
// - program starts only with write enable latch set
// - ragged frame end: no program, no flags
// - address bits sampled on rising serial clock
// - protected sector: skip, keep latch, set flags
// - timeout clears latch, sets program error flag
// - decode 02h, 32h, 38h as program commands
// - decode a2h, d2h as dual program commands
// - programming only turns ones into zeros
// - write in progress high while programming runs
// - latch cleared when programming ends, any outcome
// - status and flags readable while programming
// - suspend pauses programming, resume continues it
// - bytes past page end wrap to page start
// - overflow keeps only the last page of bytes
// - short program leaves other page bytes alone
// - 06h sets write enable latch, 04h clears
// - after protection error 50h clears latch, 04h does not
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// command opcodes
`define SFP_OP_PP    8'h02
`define SFP_OP_QPP   8'h32
`define SFP_OP_XQPP  8'h38
`define SFP_OP_DPP   8'ha2
`define SFP_OP_XDPP  8'hd2
`define SFP_OP_WREN  8'h06
`define SFP_OP_WRDI  8'h04
`define SFP_OP_CLFS  8'h50
`define SFP_OP_RDSR  8'h05
`define SFP_OP_RDFS  8'h70
`define SFP_OP_SUSP  8'h75
`define SFP_OP_RESM  8'h7a

// status and flag status bit positions
`define SFP_SR_WIP   0
`define SFP_SR_WEL   1
`define SFP_FS_PROT  1
`define SFP_FS_PSUS  2
`define SFP_FS_PERR  4
`define SFP_FS_EERR  5
`define SFP_FS_RDY   7

// array geometry and reset values
`define SFP_PAGE_BYTES 256
`define SFP_ARR_BYTES  4096
`define SFP_ERASED     8'hff
`define SFP_MIN_PGM    3'd5

// timing: program time and timeout in ns, core clock period in ns
`define SFP_CLK_NS  10
`define SFP_T_PP_NS 1000
`define SFP_T_TO_NS 5000
`define SFP_PP_CYC  ((`SFP_T_PP_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_TO_CYC  (`SFP_T_TO_NS / `SFP_CLK_NS)

`endif

/* core/sfp_pkg.sv */
// types of the serial flash page program block
package sfp_pkg;

  // lane protocol selected by the configuration pins
  typedef enum logic [1:0] {
    PROTO_EXT  = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } sfp_proto_t;

  // program engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WAIT  = 4'h2,
    ST_APPLY = 4'h4,
    ST_END   = 4'h8
  } sfp_state_t;

  // what one frame left behind on the link side
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  bcnt;
    logic [2:0]  bitpos;
  } sfp_frame_t;

  // status pair shipped to the link side
  typedef struct packed {
    logic [7:0] fsr;
    logic [7:0] sr;
  } sfp_stat_t;

endpackage : sfp_pkg

/* core/sfp_sync.sv */
// two-flop level synchroniser
module sfp_sync #(
  parameter int unsigned W  = 1,
  parameter logic        RV = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q; // first stage, read by the second only

  // both stages reset to the chosen idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{RV}};
      q      <= {W{RV}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sfp_sync

/* verification/sfp_host.sv */
// spi host model that drives the link side of the flash
module sfp_host (
  output logic            spi_sck,
  output logic            cs_n,
  output logic      [3:0] dq,
  input  wire logic [3:0] dq_o,
  input  wire logic [3:0] oe
);
  timeunit 1ns;
  timeprecision 100ps;
  int wo = 1; // opcode lanes, set by the bench per protocol
  // clock stands still outside frames
  initial begin
    spi_sck = 1'b0;
    cs_n = 1'b1;
    dq = 4'h0;
  end
  // one byte, w lanes per edge, msb first, set after the falling edge
  task automatic shift(input logic [7:0] b, input int w);
    for (int i = 0; i < 8; i += w) begin
      dq = 4'(8'(b << i) >> (8 - w));
      #3 spi_sck = 1'b1;
      #3 spi_sck = 1'b0;
    end
  endtask : shift
  // whole frame; x stray single edges make a ragged end
  task automatic frame(input logic [7:0] b[$], input int wa, wd, x);
    cs_n = 1'b0;
    #3;
    foreach (b[k]) shift(b[k], k == 0 ? wo : (k < 4 ? wa : wd));
    repeat (x) shift(8'h00, 8);
    #3 cs_n = 1'b1;
    dq = ~dq; // released lines must not keep the old level
    #100; // long gap so the core can copy the frame
  endtask : frame
  // status read on the extended output lane
  task automatic rd_sr(input logic [7:0] o, output logic [7:0] s,
                       output logic [3:0] e);
    cs_n = 1'b0;
    #3;
    shift(o, 1);
    repeat (8) begin
      #3 spi_sck = 1'b1;
      s = {s[6:0], dq_o[1]};
      e = oe;
      #3 spi_sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    #100;
  endtask : rd_sr
endmodule : sfp_host

/* verification/serial_flash_page_program_tb.sv */
// self-checking bench of the page program block
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  n_errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module serial_flash_page_program_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] prot_sect;
  logic [1:0]  proto_mode;
  logic        pgm_stall;
  logic [11:0] rd_addr;
  logic        spi_sck, cs_n;
  logic [3:0]  dq_in, dq_out, dq_oe, e;
  logic [7:0]  rd_data, status_out, flag_out, s;
  int          n_errors, num_checks;
  always #5 core_clk = ~core_clk;
  sfp_host host (.spi_sck, .cs_n, .dq(dq_in), .dq_o(dq_out), .oe(dq_oe));
  // mode pins change only between frames
  sfp_top uut (.core_clk, .rst_n, .spi_sck, .cs_n, .dq_in, .dq_out,
    .dq_oe, .proto_mode, .prot_sect, .pgm_stall, .rd_addr,
    .rd_data, .status_out, .flag_out);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // array byte through the read port, one cycle latency
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk) rd_addr <= a;
    cyc(2);
    `CHK("array", e, rd_data)
  endtask : rd
  task automatic op(input logic [7:0] o, input int x);
    host.frame({o}, 1, 1, x);
  endtask : op
  task automatic pgm(input logic [7:0] o, input int wa, wd,
                     input logic [11:0] a, input logic [7:0] d[$]);
    host.frame({o, 8'h00, 8'(a[11:8]), a[7:0], d}, wa, wd, 0);
  endtask : pgm
  // bounded wait for write in progress to drop
  task automatic idle();
    for (int i = 0; i < 3000 && status_out[0] !== 1'b0; i++) cyc(1);
    `CHK("wip idle", 1'b0, status_out[0])
  endtask : idle
  task automatic t_wel();
    op(8'h06, 0);
    `CHK("status", 8'h02, status_out)
    op(8'h04, 0);
    `CHK("status", 8'h00, status_out)
    pgm(8'h02, 1, 1, 12'h010, {8'h00});
    `CHK("status", 8'h00, status_out)
    rd(12'h010, 8'hff);
  endtask : t_wel
  // start near page end so the bytes wrap, then poll while busy
  task automatic t_wrap();
    op(8'h06, 0);
    pgm(8'h02, 1, 1, 12'h0fe, {8'ha5, 8'h3c, 8'h0f});
    `CHK("wip", 1'b1, status_out[0])
    host.rd_sr(8'h05, s, e);
    `CHK("polled wip", 1'b1, s[0])
    `CHK("read lanes", 4'h2, e)
    `CHK("lanes freed", 4'h0, dq_oe)
    idle();
    `CHK("status", 8'h00, status_out)
    rd(12'h0fe, 8'ha5);
    rd(12'h000, 8'h0f);
    rd(12'h001, 8'hff);
    op(8'h06, 0);
    pgm(8'h02, 1, 1, 12'h0fe, {8'h0f});
    idle();
    rd(12'h0fe, 8'h05);
  endtask : t_wrap
  task automatic t_ragged();
    op(8'h06, 0);
    host.frame({8'h02, 8'h00, 8'h00, 8'h20, 8'h00}, 1, 1, 3);
    `CHK("status", 8'h02, status_out)
    `CHK("flags", 8'h80, flag_out)
    rd(12'h020, 8'hff);
  endtask : t_ragged
  // latch still set from the ragged frame
  task automatic t_prot();
    @(posedge core_clk) prot_sect <= 16'h0004;
    pgm(8'h02, 1, 1, 12'h230, {8'h00});
    `CHK("flags", 8'h92, flag_out)
    op(8'h04, 0);
    `CHK("status", 8'h02, status_out)
    op(8'h50, 3);
    `CHK("flags", 8'h80, flag_out)
    `CHK("status", 8'h00, status_out)
    rd(12'h230, 8'hff);
    @(posedge core_clk) prot_sect <= 16'h0000;
  endtask : t_prot
  task automatic t_tout();
    @(posedge core_clk) pgm_stall <= 1'b1;
    op(8'h06, 0);
    pgm(8'h02, 1, 1, 12'h040, {8'h00});
    idle();
    `CHK("flags", 8'h90, flag_out)
    `CHK("status", 8'h00, status_out)
    rd(12'h040, 8'hff);
    @(posedge core_clk) pgm_stall <= 1'b0;
    op(8'h50, 0);
  endtask : t_tout
  // remaining program opcodes with their lane widths
  task automatic t_ops();
    logic [7:0] o[4] = '{8'h32, 8'h38, 8'ha2, 8'hd2};
    int wa[4] = '{1, 4, 1, 2};
    int wd[4] = '{4, 4, 2, 2};
    for (int i = 0; i < 4; i++) begin
      op(8'h06, 0);
      pgm(o[i], wa[i], wd[i], 12'h300 + 12'(i), {8'h3c});
      idle();
      rd(12'h300 + 12'(i), 8'h3c);
    end
  endtask : t_ops
  // 257 bytes: the first byte must be dropped
  task automatic t_over();
    logic [7:0] d[$];
    d.push_back(8'ha5);
    repeat (255) d.push_back(8'hf0);
    d.push_back(8'h5a);
    op(8'h06, 0);
    pgm(8'h02, 1, 1, 12'h500, d);
    idle();
    rd(12'h500, 8'h5a);
    rd(12'h501, 8'hf0);
  endtask : t_over
  // dual, then quad lanes; a zero frame carries each mode across
  task automatic t_mode();
    for (int m = 1; m < 3; m++) begin
      @(posedge core_clk) proto_mode <= 2'(m);
      op(8'h00, 0);
      host.wo = 2 * m;
      op(8'h06, 0);
      pgm(8'h02, 2 * m, 2 * m, 12'h600 + 12'(m), {8'h96});
      idle();
      rd(12'h600 + 12'(m), 8'h96);
      host.wo = 1;
    end
    @(posedge core_clk) proto_mode <= 2'h0;
    op(8'h00, 0);
  endtask : t_mode
  // pause the program while it waits, poll flags, then resume
  task automatic t_susp();
    op(8'h06, 0);
    pgm(8'h02, 1, 1, 12'h700, {8'h11});
    op(8'h75, 0);
    `CHK("flags", 8'h84, flag_out)
    host.rd_sr(8'h70, s, e);
    `CHK("polled flags", 8'h84, s)
    cyc(400);
    `CHK("status", 8'h03, status_out)
    op(8'h7a, 0);
    idle();
    `CHK("flags", 8'h80, flag_out)
    rd(12'h700, 8'h11);
  endtask : t_susp
  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    prot_sect = 16'h0000;
    proto_mode = 2'h0;
    pgm_stall = 1'b0;
    rd_addr = 12'h000;
    cyc(3);
    rst_n <= 1'b1;
    cyc(3);
    `CHK("status", 8'h00, status_out)
    `CHK("flags", 8'h80, flag_out)
    t_wel();
    t_wrap();
    t_ragged();
    t_prot();
    t_tout();
    t_ops();
    t_over();
    t_mode();
    t_susp();
    complete_run();
  end
  // hang guard, well beyond the expected run
  initial begin
    #300000;
    n_errors++;
    complete_run();
  end
endmodule : serial_flash_page_program_tb
